/* hdl/pds_pkg.sv */
// pds_pkg: constants and carrier types for the sleep-hold / security control block
// assumes a single 10 MHz core clock and an active-high asynchronous reset
// Function
// - 64-bit signature always readable, secured or not
// - secured part refuses verify readback and preload
// - security fuse acts immediately once programmed
// - pin keepers hold last driven level
// - sleep pin high latches outputs and state
// - undetermined outputs keep state through sleep
// - sleep ignores all inputs but sleep pin and signature access
// - hold latches stay active during sleep
// - enabled sleep pin never feeds array
// - separate configuration bit enables sleep
// - sleep disabled: shared pin is ordinary input
// - twelve inputs, ten macrocells, shared term array
// - each macrocell registered/combinational, high/low polarity
// - reset clears all macrocell registers low
// - unsecured registers accept forced high/low preload
package pds_pkg;
    // ========================================================
    // sizes
    localparam int PDS_N_IN    = 12;  // dedicated inputs, shared pin is the last
    localparam int PDS_N_MC    = 10;  // macrocells
    localparam int PDS_SIG_W   = 64;  // user signature bits
    localparam int PDS_SIG_AW  = 3;   // signature byte address
    localparam int PDS_SHARED  = 11;  // index of the shared input/sleep pin
    // reset values
    localparam logic [9:0] PDS_MC_RST = 10'h000;
    // ========================================================
    // per-macrocell configuration carrier
    typedef struct packed {
        logic [9:0] registered;  // 1: registered output, 0: combinational
        logic [9:0] act_high;    // 1: active-high output
    } pds_cfg_s;
    // programmer access request
    typedef enum logic [1:0] {
        PDS_OP_NONE    = 2'b00,
        PDS_OP_VERIFY  = 2'b01,
        PDS_OP_PRELOAD = 2'b10,
        PDS_OP_SIGRD   = 2'b11
    } pds_op_e;
endpackage

/* hdl/pds_sig_mem.sv */
// pds_sig_mem: eight-byte user signature store with registered read data
// assumes writes come from the programmer path, same clock domain
`timescale 1ns/10ps
`default_nettype none
module pds_sig_mem
    import pds_pkg::*;
(
    // clock and reset
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst,
    // write and read
    input  wire logic                  i_we,
    input  wire logic [PDS_SIG_AW-1:0] i_addr,
    input  wire logic [7:0]            i_wdata,
    output logic      [7:0]            o_rdata
);
    // ========================================================
    // storage: no security gating at all here, so the signature is always readable
    typedef struct packed {
        logic [PDS_SIG_W-1:0] mem;
        logic [7:0]           rd;
    } pds_sm_s;
    pds_sm_s st_q;  // state
    pds_sm_s st_d;  // next state

    // next-state logic
    always_comb begin
        st_d = st_q;
        if (i_we) begin
            st_d.mem[i_addr*8 +: 8] = i_wdata;
        end
        st_d.rd = st_q.mem[i_addr*8 +: 8];
    end

    // register
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_rdata = st_q.rd;
endmodule
`default_nettype wire

/* hdl/pds_ctrl.sv */
// pds_ctrl: sleep-hold pin control, security gating of verify and preload,
// pin keepers and the ten macrocell output stages around a term array input
// assumes pins are asynchronous (double-synchronised here) and the product-term
// array sits outside, feeding i_term and reading o_array_in
`timescale 1ns/10ps
`default_nettype none
module pds_ctrl
    import pds_pkg::*;
(
    // clock and reset
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst,
    // pins
    input  wire logic [PDS_N_IN-1:0]   i_in_pin,     // dedicated inputs, bit 11 shared
    input  wire logic [PDS_N_IN-1:0]   i_in_drv,     // 1 while board drives the input
    input  wire logic [PDS_N_MC-1:0]   i_io_pin,     // io pin level seen from board
    input  wire logic [PDS_N_MC-1:0]   i_io_drv,     // 1 while board drives an io pin
    // term array interface
    input  wire logic [PDS_N_MC-1:0]   i_term,       // sum-of-products per macrocell
    input  wire logic [PDS_N_MC-1:0]   i_oe_term,    // output enable per macrocell
    output logic      [PDS_N_IN-1:0]   o_array_in,   // kept inputs into the array
    output logic      [PDS_N_MC-1:0]   o_feedback,   // buried register feedback
    output logic      [PDS_N_MC-1:0]   o_io_out,
    output logic      [PDS_N_MC-1:0]   o_io_oe,
    output logic      [PDS_N_MC-1:0]   o_io_keep,    // keeper level on io pins
    // configuration
    input  wire logic                  i_sleep_en,   // dedicated sleep-enable bit
    input  wire pds_cfg_s              i_cfg,
    input  wire logic                  i_secure,     // security fuse state
    // programmer access
    input  wire pds_op_e               i_op,
    input  wire logic [PDS_N_MC-1:0]   i_pre_val,
    input  wire logic [PDS_SIG_AW-1:0] i_sig_addr,
    input  wire logic                  i_sig_we,
    input  wire logic [7:0]            i_sig_wdata,
    output logic      [7:0]            o_sig_rdata,
    output logic      [PDS_N_MC-1:0]   o_verify_data,
    output logic                       o_refused,    // one-cycle pulse
    output logic                       o_sleeping
);
    // ========================================================
    // state record
    typedef struct packed {
        logic [PDS_N_IN-1:0] in_s1;    // first sync stage, read only by in_s2
        logic [PDS_N_IN-1:0] in_s2;
        logic [PDS_N_MC-1:0] io_s1;
        logic [PDS_N_MC-1:0] io_s2;
        logic [PDS_N_IN-1:0] drv_s1;
        logic [PDS_N_IN-1:0] drv_s2;
        logic [PDS_N_MC-1:0] iod_s1;
        logic [PDS_N_MC-1:0] iod_s2;
        logic [PDS_N_IN-1:0] in_keep;  // keeper latch per input
        logic [PDS_N_MC-1:0] io_keep;  // keeper latch per io
        logic [PDS_N_MC-1:0] mc;       // macrocell registers
        logic [PDS_N_MC-1:0] out;
        logic [PDS_N_MC-1:0] oe;
        logic [PDS_N_IN-1:0] arr;
        logic [PDS_N_MC-1:0] vfy;
        logic                refused;
        logic                sleeping;
    } pds_st_s;
    pds_st_s st_q;  // state
    pds_st_s st_d;  // next state
    logic    sleep_now;  // sleep requested by synchronised shared pin

    // ========================================================
    // signature store, never gated by the fuse
    pds_sig_mem u_sig (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_we       (i_sig_we),
        .i_addr     (i_sig_addr),
        .i_wdata    (i_sig_wdata),
        .o_rdata    (o_sig_rdata)
    );

    // sleep only when enabled; the pin alone does nothing otherwise
    assign sleep_now = i_sleep_en & st_q.in_s2[PDS_SHARED];

    // ========================================================
    // next-state logic
    always_comb begin
        st_d = st_q;
        // synchronisers always run; the sleep pin must stay visible
        st_d.in_s1  = i_in_pin;
        st_d.in_s2  = st_q.in_s1;
        st_d.io_s1  = i_io_pin;
        st_d.io_s2  = st_q.io_s1;
        st_d.drv_s1 = i_in_drv;
        st_d.drv_s2 = st_q.drv_s1;
        st_d.iod_s1 = i_io_drv;
        st_d.iod_s2 = st_q.iod_s1;
        st_d.refused = 1'b0;
        st_d.sleeping = sleep_now;
        if (!sleep_now) begin
            // keepers follow driven pins only, undriven pins keep last level
            for (int i = 0; i < PDS_N_IN; i++) begin
                if (st_q.drv_s2[i]) begin
                    st_d.in_keep[i] = st_q.in_s2[i];
                end
            end
            for (int j = 0; j < PDS_N_MC; j++) begin
                if (st_q.iod_s2[j]) begin
                    st_d.io_keep[j] = st_q.io_s2[j];
                end
                // four output choices per macrocell
                st_d.out[j] = (i_cfg.registered[j] ? st_q.mc[j] : i_term[j])
                              ^ ~i_cfg.act_high[j];
                st_d.oe[j]  = i_oe_term[j];
            end
            // registers advance from whatever they held; no reset on wake
            st_d.mc = i_term;
            st_d.arr = st_q.in_keep;
            // shared pin is not an array input when sleep is enabled
            if (i_sleep_en) begin
                st_d.arr[PDS_SHARED] = 1'b0;
            end
            // programmer operations
            unique case (i_op)
                PDS_OP_VERIFY: begin
                    if (i_secure) begin
                        st_d.refused = 1'b1;
                        st_d.vfy = '0;
                    end else begin
                        st_d.vfy = st_q.mc;
                    end
                end
                PDS_OP_PRELOAD: begin
                    if (i_secure) begin
                        st_d.refused = 1'b1;
                    end else begin
                        st_d.mc = i_pre_val;
                    end
                end
                PDS_OP_SIGRD: begin
                    st_d.vfy = st_q.vfy;
                end
                PDS_OP_NONE: begin
                    st_d.vfy = st_q.vfy;
                end
            endcase
        end
        // while asleep every field set in the branch above holds, keepers included, except refused, which clears to 0
    end

    // register; registers clear low at reset, outputs then follow polarity
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ========================================================
    // outputs straight from the state record
    assign o_array_in    = st_q.arr;
    assign o_feedback    = st_q.mc;
    assign o_io_out      = st_q.out;
    assign o_io_oe       = st_q.oe;
    assign o_io_keep     = st_q.io_keep;
    assign o_verify_data = st_q.vfy;
    assign o_refused     = st_q.refused;
    assign o_sleeping    = st_q.sleeping;

    // ========================================================
    // checks
    sequence s_asleep;
        st_q.sleeping ##1 st_q.sleeping;
    endsequence

    AST_SIG_FREE: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_op == PDS_OP_SIGRD) |=> !o_refused)
        else $error("signature access refused");
    AST_SEC_VFY: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_secure && i_op == PDS_OP_VERIFY && !sleep_now) |=> (o_refused && o_verify_data == '0))
        else $error("verify not refused while secured");
    AST_SEC_PRE: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_secure && i_op == PDS_OP_PRELOAD && !sleep_now) |=> o_refused)
        else $error("preload not refused while secured");
    AST_PRELOAD: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (!i_secure && i_op == PDS_OP_PRELOAD && !sleep_now) |=> (o_feedback == $past(i_pre_val)))
        else $error("preload value not loaded");
    AST_HOLD_OUT: assert property (@(posedge i_core_clk) disable iff (i_rst)
        s_asleep |-> $stable(o_io_out) && $stable(o_feedback))
        else $error("outputs changed during sleep");
    AST_HOLD_KEEP: assert property (@(posedge i_core_clk) disable iff (i_rst)
        s_asleep |-> $stable(o_io_keep) && $stable(o_array_in))
        else $error("keepers changed during sleep");
    AST_NO_SLEEP: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !i_sleep_en |=> !o_sleeping)
        else $error("sleep entered while disabled");
    AST_SHARED_BLK: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_sleep_en && !sleep_now) |=> !o_array_in[PDS_SHARED])
        else $error("shared pin reached array");
    AST_RESUME: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (!sleep_now && i_op == PDS_OP_NONE) |=> (o_feedback == $past(i_term)))
        else $error("registers did not resume");
endmodule
`default_nettype wire

/* verif/pds_board.sv */
// pds_board: board logic driving the input or io pins of the block
// assumes the block clock; a released pin toggles so only a keeper holds it
`timescale 1ns/10ps
`default_nettype none
module pds_board #(
    parameter int W = 12
) (
    // clock and wanted levels
    input  wire logic         i_clk,
    input  wire logic [W-1:0] i_val,
    input  wire logic [W-1:0] i_drive,
    // pin levels and drive flags
    output logic      [W-1:0] o_pin = '0,
    output logic      [W-1:0] o_drv = '0
);
    // ========================================
    // released bits toggle, so a stale level never passes for a kept one
    always_ff @(posedge i_clk) begin
        for (int b = 0; b < W; b++) begin
            o_pin[b] <= i_drive[b] ? i_val[b] : ~o_pin[b];
        end
        o_drv <= i_drive;
    end
endmodule
`default_nettype wire

/* verif/tb_pld_powerdown_security_ctrl.sv */
// tb_pld_powerdown_security_ctrl: self-checking bench of pds_ctrl
// assumes pds_board models the pins; checks sampled at falling edges
`timescale 1ns/10ps
`default_nettype none
module tb_pld_powerdown_security_ctrl;
    import pds_pkg::*;
    // ========================================
    // dut ports and board requests
    logic i_core_clk, i_rst = 1'b1, i_sleep_en, i_secure, i_sig_we, o_refused, o_sleeping;
    logic [11:0] i_in_pin, i_in_drv, o_array_in, in_val, in_drive, kv;
    logic [9:0] i_io_pin, i_io_drv, i_term, i_oe_term, i_pre_val, io_val, io_drive, v, oe, iv;
    logic [9:0] o_feedback, o_io_out, o_io_oe, o_io_keep, o_verify_data;
    logic [2:0] i_sig_addr;
    logic [7:0] i_sig_wdata, o_sig_rdata;
    logic [7:0] sig [8];
    pds_cfg_s i_cfg;
    pds_op_e i_op;
    int mismatches = 0, check_count = 0;
    pds_board #(.W(12)) u_in (.i_clk(i_core_clk), .i_val(in_val), .i_drive(in_drive),
        .o_pin(i_in_pin), .o_drv(i_in_drv));
    pds_board #(.W(10)) u_io (.i_clk(i_core_clk), .i_val(io_val), .i_drive(io_drive),
        .o_pin(i_io_pin), .o_drv(i_io_drv));
    pds_ctrl dut (.i_core_clk, .i_rst, .i_in_pin, .i_in_drv, .i_io_pin, .i_io_drv, .i_term,
        .i_oe_term, .o_array_in, .o_feedback, .o_io_out, .o_io_oe, .o_io_keep, .i_sleep_en,
        .i_cfg, .i_secure, .i_op, .i_pre_val, .i_sig_addr, .i_sig_we, .i_sig_wdata,
        .o_sig_rdata, .o_verify_data, .o_refused, .o_sleeping);
    // ========================================
    // clock, watchdog and shared tasks
    initial begin
        i_core_clk = 1'b0;
        forever #50 i_core_clk = ~i_core_clk;
    end
    initial begin
        #200000;
        mismatches++;
        final_report();
    end
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge i_core_clk);
        @(negedge i_core_clk);
    endtask
    // one-cycle request; the answer is looked at one edge later
    task automatic run_op(input pds_op_e op, input logic [9:0] pv, input logic [2:0] a);
        @(posedge i_core_clk);
        i_op <= op;
        i_pre_val <= pv;
        i_sig_addr <= a;
        @(posedge i_core_clk);
        i_op <= PDS_OP_NONE;
        @(negedge i_core_clk);
    endtask
    // output level from register or term, then polarity
    function automatic logic [9:0] exp_out(logic [9:0] fb, logic [9:0] t, pds_cfg_s c);
        return ((c.registered & fb) | (~c.registered & t)) ~^ c.act_high;
    endfunction
    // ========================================
    // main sequence
    initial begin
        {in_val, io_val, i_term, i_oe_term, i_pre_val, i_sig_addr, i_sig_wdata} = '0;
        {in_drive, io_drive} = '1;
        {i_sleep_en, i_secure, i_sig_we, i_cfg} = '0;
        i_op = PDS_OP_NONE;
        void'($urandom(74));
        repeat (6) @(posedge i_core_clk);
        i_rst <= 1'b0;
        settle(1);
        chk(o_feedback, PDS_MC_RST);
        $display("reset test done");
        // all four output modes, preload and verify
        for (int m = 0; m < 4; m++) begin
            v = 10'($urandom);
            @(posedge i_core_clk);
            i_cfg <= '{registered: {10{m[0]}}, act_high: {10{m[1]}}};
            i_term <= v;
            run_op(PDS_OP_PRELOAD, v, 3'h0);
            chk(o_feedback, v);
            settle(4);
            chk(o_io_out, exp_out(v, v, i_cfg));
            run_op(PDS_OP_VERIFY, 10'h000, 3'h0);
            chk({o_refused, o_verify_data}, {1'b0, v});
        end
        $display("mode test done");
        // fuse set, then the next verify and preload are refused
        @(posedge i_core_clk);
        i_secure <= 1'b1;
        run_op(PDS_OP_VERIFY, 10'h000, 3'h0);
        chk({o_refused, o_verify_data}, {1'b1, 10'h000});
        run_op(PDS_OP_PRELOAD, ~v, 3'h0);
        chk({o_refused, o_feedback}, {1'b1, v});
        // signature written back to back, read while secured
        for (int k = 0; k < 8; k++) begin
            sig[k] = 8'($urandom);
            @(posedge i_core_clk);
            {i_sig_we, i_sig_addr, i_sig_wdata} <= {1'b1, 3'(k), sig[k]};
        end
        @(posedge i_core_clk);
        i_sig_we <= 1'b0;
        for (int k = 0; k < 8; k++) begin
            run_op(PDS_OP_SIGRD, 10'h000, 3'(k));
            chk(o_sig_rdata, sig[k]);
        end
        i_secure <= 1'b0;
        $display("security test done");
        // keepers hold the last driven level once released
        kv = {1'b0, 11'($urandom)};
        iv = 10'($urandom);
        {in_val, io_val} <= {kv, iv};
        settle(4);
        {in_drive, io_drive} <= '0;
        settle(6);
        chk({o_array_in, o_io_keep}, {kv, iv});
        {in_drive, io_drive, i_sleep_en} <= {22'h3FFFFF, 1'b1};
        oe = 10'($urandom);
        i_oe_term <= oe;
        settle(4);
        chk({o_array_in[11], o_sleeping}, 2'b00);
        // sleep freezes state and blocks inputs
        in_val[11] <= 1'b1;
        settle(4);
        chk(o_sleeping, 1'b1);
        {i_term, i_oe_term, in_val, io_val} <= {~v, ~oe, 1'b1, ~kv[10:0], ~iv};
        run_op(PDS_OP_PRELOAD, ~v, 3'h0);
        settle(4);
        chk({o_feedback, o_io_out, o_io_oe}, {v, exp_out(v, v, i_cfg), oe});
        chk({o_array_in, o_io_keep}, {1'b0, kv[10:0], iv});
        i_term <= v;
        in_val[11] <= 1'b0;
        // keeper updates one edge after wake, array input one edge later still
        settle(5);
        chk({o_sleeping, o_feedback, o_array_in}, {1'b0, v, 1'b0, ~kv[10:0]});
        // feature off: shared pin is a plain input
        {i_sleep_en, in_val[11]} <= 2'b01;
        // board, two sync stages, keeper, array register: five edges
        settle(5);
        chk({o_sleeping, o_array_in[11]}, 2'b01);
        $display("sleep test done");
        final_report();
    end
endmodule
`default_nettype wire
